/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sapc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic regWrEn = 1'b0;
    logic [WORD_W-1:0] regWrData = 32'h00000000;
    logic [WORD_W-1:0] regRdData;
    logic [NUM_SP-1:0] compareResult = 16'h0000;
    logic [NUM_PID-1:0] pidEnable = 5'h00;
    logic manWrEn = 1'b0;
    logic [MAN_IDX_W-1:0] manWrIdx = 3'h0;
    logic [LOOP_W-1:0] manWrData = 16'h0000;
    logic [NUM_PID-1:0] pidAlgoValid = 5'h00;
    logic [NUM_PID*LOOP_W-1:0] pidAlgoErr, pidAlgoInt, pidAlgoOut;
    logic [NUM_SP-1:0] setpointState, setpointRemote;
    logic [NUM_PID*MODE_W-1:0] loopMode;
    logic [NUM_PID*LOOP_W-1:0] loopOutput, loopPrevError, loopIntegral;
    logic [NUM_SP-1:0] cmp, rem, st, expSt;
    int err_total = 0;
    int samples_checked = 0;

    always #50 sys_clk = ~sys_clk;

    sapc_top sapc_top_inst (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
        .compareResult(compareResult), .pidEnable(pidEnable),
        .manWrEn(manWrEn), .manWrIdx(manWrIdx), .manWrData(manWrData),
        .pidAlgoValid(pidAlgoValid), .pidAlgoErr(pidAlgoErr),
        .pidAlgoInt(pidAlgoInt), .pidAlgoOut(pidAlgoOut),
        .setpointState(setpointState), .setpointRemote(setpointRemote),
        .loopMode(loopMode), .loopOutput(loopOutput),
        .loopPrevError(loopPrevError), .loopIntegral(loopIntegral));

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle strobe; a negedge passes first so strobes never merge
    task automatic wr(input logic [WORD_W-1:0] d);
        @(negedge sys_clk);
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
    endtask

    task automatic mw(input int i, input logic [LOOP_W-1:0] d);
        @(negedge sys_clk);
        manWrIdx = i[MAN_IDX_W-1:0];
        manWrData = d;
        manWrEn = 1'b1;
        @(negedge sys_clk);
        manWrEn = 1'b0;
    endtask

    // Auto mode: mode word and the three registers follow the algorithm
    task automatic chkAuto(input int i);
        check("loopMode", loopMode[i*MODE_W +: MODE_W], SAPC_AUTO);
        check("loopOutput", loopOutput[i*LOOP_W +: LOOP_W],
            16'h3000 + i[15:0]);
        check("loopPrevError", loopPrevError[i*LOOP_W +: LOOP_W],
            16'h1000 + i[15:0]);
        check("loopIntegral", loopIntegral[i*LOOP_W +: LOOP_W],
            16'h2000 + i[15:0]);
    endtask

    task print_verdict;
        if (err_total == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < NUM_PID; i++) begin
            pidAlgoErr[i*LOOP_W +: LOOP_W] = 16'h1000 + i[15:0];
            pidAlgoInt[i*LOOP_W +: LOOP_W] = 16'h2000 + i[15:0];
            pidAlgoOut[i*LOOP_W +: LOOP_W] = 16'h3000 + i[15:0];
        end
        tick(16);
        rst = 1'b0;
        check("regRdData", regRdData, 32'h00000000);
        for (int i = 0; i < NUM_PID; i++) begin
            check("loopMode", loopMode[i*MODE_W +: MODE_W], SAPC_AUTO);
        end
        // Normal mode: compare drives state, a status write does not stick
        cmp = 16'hA5C3;
        compareResult = cmp;
        tick(1);
        check("setpointState", setpointState, cmp);
        wr({16'h0000, ~cmp});
        check("setpointState", setpointState, cmp);
        tick(1);
        check("regRdData", regRdData, {16'h0000, cmp});
        // Mixed remote and normal setpoints, then the compare moves
        rem = 16'hF0E1;
        st = 16'h3C5A;
        wr({rem, st});
        expSt = (rem & st) | (~rem & cmp);
        check("setpointState", setpointState, expSt);
        check("setpointRemote", setpointRemote, rem);
        cmp = ~cmp;
        compareResult = cmp;
        tick(2);
        expSt = (rem & st) | (~rem & cmp);
        check("setpointState", setpointState, expSt);
        check("regRdData", regRdData, {rem, expSt});
        // Loops 2 to 5 enabled; loop 1 stays a plain setpoint
        pidEnable = 5'h1E;
        pidAlgoValid = 5'h1F;
        for (int i = 0; i < NUM_PID; i++) begin
            mw(i, 16'h4000 + i[15:0]);
        end
        tick(2);
        for (int i = 1; i < NUM_PID; i++) begin
            chkAuto(i);
        end
        st = 16'h000B;
        wr({16'h001F, st});
        tick(2);
        check("loopMode", loopMode[0 +: MODE_W], SAPC_AUTO);
        for (int i = 1; i < NUM_PID; i++) begin
            check("loopMode", loopMode[i*MODE_W +: MODE_W],
                st[i] ? SAPC_MANUAL : SAPC_OFF);
            check("loopOutput", loopOutput[i*LOOP_W +: LOOP_W],
                st[i] ? 16'h4000 + i[15:0] : 16'h0000);
            if (!st[i]) begin
                check("loopPrevError",
                    loopPrevError[i*LOOP_W +: LOOP_W], 16'h0000);
                check("loopIntegral",
                    loopIntegral[i*LOOP_W +: LOOP_W], 16'h0000);
            end
        end
        // Clearing the remote flags returns every loop to auto
        wr({16'h0000, st});
        tick(2);
        for (int i = 1; i < NUM_PID; i++) begin
            chkAuto(i);
        end
        // Reset in mid-run drops all remote flags
        wr(32'hFFFFFFFF);
        tick(1);
        rst = 1'b1;
        tick(1);
        rst = 1'b0;
        check("setpointRemote", setpointRemote, 16'h0000);
        for (int i = 0; i < NUM_PID; i++) begin
            check("loopMode", loopMode[i*MODE_W +: MODE_W], SAPC_AUTO);
        end
        // Clock enable low freezes flags and readback despite a write
        clkEn = 1'b0;
        compareResult = 16'hFFFF;
        wr(32'hFFFFFFFF);
        tick(2);
        check("setpointRemote", setpointRemote, 16'h0000);
        check("setpointState", setpointState, 16'h0000);
        check("regRdData", regRdData, 32'h00000000);
        clkEn = 1'b1;
        tick(1);
        check("setpointState", setpointState, 16'hFFFF);
        print_verdict();
    end
endmodule // tb
`default_nettype wire

/* hw/sapc_loop_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sapc_loop_if;
    import sapc_pkg::*;
    logic pidEnable;
    logic remote;
    logic state;
    logic [LOOP_W-1:0] manualValue;
    logic algoValid;
    logic [LOOP_W-1:0] algoErr;
    logic [LOOP_W-1:0] algoInt;
    logic [LOOP_W-1:0] algoOut;
    sapc_mode_t mode;
    logic [LOOP_W-1:0] prevError;
    logic [LOOP_W-1:0] integral;
    logic [LOOP_W-1:0] outValue;

    modport ctrl (
        output pidEnable, remote, state, manualValue,
        output algoValid, algoErr, algoInt, algoOut,
        input mode, prevError, integral, outValue
    );
    modport loop (
        input pidEnable, remote, state, manualValue,
        input algoValid, algoErr, algoInt, algoOut,
        output mode, prevError, integral, outValue
    );
endinterface
`default_nettype wire

/* hw/sapc_pid_loop.sv */
`timescale 1ns/1ps
`default_nettype none
module sapc_pid_loop (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    sapc_loop_if.loop lp
);
    import sapc_pkg::*;
    sapc_mode_t next_mode;
    logic [LOOP_W-1:0] next_prevError;
    logic [LOOP_W-1:0] next_integral;
    logic [LOOP_W-1:0] next_outValue;

    always_comb begin
        next_mode = SAPC_AUTO;
        if (lp.pidEnable && lp.remote) begin
            next_mode = lp.state ? SAPC_MANUAL : SAPC_OFF;
        end
        next_prevError = lp.prevError;
        next_integral = lp.integral;
        next_outValue = lp.outValue;
        case (next_mode)
            SAPC_OFF: begin
                next_prevError = LOOP_RST;
                next_integral = LOOP_RST;
                next_outValue = LOOP_RST;
            end
            SAPC_MANUAL: begin
                next_outValue = lp.manualValue;
            end
            default: begin
                if (lp.pidEnable && lp.algoValid) begin
                    next_prevError = lp.algoErr;
                    next_integral = lp.algoInt;
                    next_outValue = lp.algoOut;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lp.mode <= SAPC_AUTO;
            lp.prevError <= LOOP_RST;
            lp.integral <= LOOP_RST;
            lp.outValue <= LOOP_RST;
        end else if (clkEn) begin
            lp.mode <= next_mode;
            lp.prevError <= next_prevError;
            lp.integral <= next_integral;
            lp.outValue <= next_outValue;
        end
    end
endmodule // sapc_pid_loop
`default_nettype wire

/* hw/sapc_pkg.sv */
// Summary of operation
// - Read bits 0 to 15 return setpoints 1 to 16 state, 1 on.
// - Bits 16 to 31 hold remote flags of setpoints 1 to 16.
// - For a PID setpoint remote 1 means manual or off, 0 auto.
// - Remote plain setpoint: written status bit forces it off or on.
// - Remote PID setpoint: status 0 turns output off, 1 selects manual.
// - Writing remote 1 moves a loop to manual/off, 0 back to auto.
// - Status bits show setpoint state only, never relay state.
// - PID operation exists only for setpoints 1 to 5.
// - PID setpoints start in auto mode after reset.
// - Remote 0 runs loop in auto from the algorithm, status ignored.
// - Remote and status both 1: loop output equals manual-output value.
// - Remote 1, status 0: stop loop, clear error, integral and output.
// - Setpoints 6 to 16 take written status plainly as off or on.
// - Normal mode: state comes from the input versus setpoint compare.
// - Remote mode: only status writes change the setpoint state.
package sapc_pkg;
    localparam int WORD_W = 32;
    localparam int NUM_SP = 16;
    localparam int NUM_PID = 5;
    localparam int STATE_LSB = 0;
    localparam int REMOTE_LSB = 16;
    localparam int LOOP_W = 16;
    localparam int MAN_IDX_W = 3;
    localparam logic [NUM_SP-1:0] STATE_RST = 16'h0000;
    localparam logic [NUM_SP-1:0] REMOTE_RST = 16'h0000;
    localparam logic [LOOP_W-1:0] LOOP_RST = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;
    localparam int MODE_W = 3;

    typedef enum logic [MODE_W-1:0] {
        SAPC_AUTO = 3'h1,
        SAPC_MANUAL = 3'h2,
        SAPC_OFF = 3'h4
    } sapc_mode_t;
endpackage

/* hw/sapc_setpoint_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module sapc_setpoint_cell (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic wrEn,
    input wire logic wrState,
    input wire logic wrRemote,
    input wire logic compareIn,
    output logic state,
    output logic remote
);
    import sapc_pkg::*;
    logic next_state;
    logic next_remote;

    always_comb begin
        next_remote = remote;
        next_state = state;
        if (wrEn) begin
            next_remote = wrRemote;
        end
        if (wrEn && wrRemote) begin
            next_state = wrState;
        end else if (!next_remote) begin
            next_state = compareIn;
        end
        // Remote without a write holds the state
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= STATE_RST[0];
            remote <= REMOTE_RST[0];
        end else if (clkEn) begin
            state <= next_state;
            remote <= next_remote;
        end
    end
endmodule // sapc_setpoint_cell
`default_nettype wire

/* hw/sapc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sapc_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic regWrEn,
    input wire logic [sapc_pkg::WORD_W-1:0] regWrData,
    output logic [sapc_pkg::WORD_W-1:0] regRdData,
    input wire logic [sapc_pkg::NUM_SP-1:0] compareResult,
    input wire logic [sapc_pkg::NUM_PID-1:0] pidEnable,
    input wire logic manWrEn,
    input wire logic [sapc_pkg::MAN_IDX_W-1:0] manWrIdx,
    input wire logic [sapc_pkg::LOOP_W-1:0] manWrData,
    input wire logic [sapc_pkg::NUM_PID-1:0] pidAlgoValid,
    input wire logic [sapc_pkg::NUM_PID*sapc_pkg::LOOP_W-1:0] pidAlgoErr,
    input wire logic [sapc_pkg::NUM_PID*sapc_pkg::LOOP_W-1:0] pidAlgoInt,
    input wire logic [sapc_pkg::NUM_PID*sapc_pkg::LOOP_W-1:0] pidAlgoOut,
    output logic [sapc_pkg::NUM_SP-1:0] setpointState,
    output logic [sapc_pkg::NUM_SP-1:0] setpointRemote,
    output logic [sapc_pkg::NUM_PID*sapc_pkg::MODE_W-1:0] loopMode,
    output logic [sapc_pkg::NUM_PID*sapc_pkg::LOOP_W-1:0] loopOutput,
    output logic [sapc_pkg::NUM_PID*sapc_pkg::LOOP_W-1:0] loopPrevError,
    output logic [sapc_pkg::NUM_PID*sapc_pkg::LOOP_W-1:0] loopIntegral
);
    import sapc_pkg::*;

    logic [NUM_SP-1:0] stateVec;
    logic [NUM_SP-1:0] remoteVec;
    logic [LOOP_W-1:0] manualValue [NUM_PID];
    logic [LOOP_W-1:0] next_manualValue [NUM_PID];
    logic [WORD_W-1:0] next_regRdData;
    sapc_mode_t modeVec [NUM_PID];

    // Setpoint state and remote flags, one cell per setpoint
    genvar g;
    generate
        for (g = 0; g < NUM_SP; g++) begin : gSp
            sapc_setpoint_cell uCell (
                .sys_clk(sys_clk),
                .rst(rst),
                .clkEn(clkEn),
                .wrEn(regWrEn),
                .wrState(regWrData[STATE_LSB+g]),
                .wrRemote(regWrData[REMOTE_LSB+g]),
                .compareIn(compareResult[g]),
                .state(stateVec[g]),
                .remote(remoteVec[g])
            );
        end
    endgenerate

    // Loop manual-output values, written by index
    always_comb begin
        for (int i = 0; i < NUM_PID; i++) begin
            next_manualValue[i] = manualValue[i];
            if (manWrEn && manWrIdx == MAN_IDX_W'(i)) begin
                next_manualValue[i] = manWrData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < NUM_PID; i++) begin
                manualValue[i] <= LOOP_RST;
            end
        end else if (clkEn) begin
            for (int i = 0; i < NUM_PID; i++) begin
                manualValue[i] <= next_manualValue[i];
            end
        end
    end

    // Only the first setpoints carry a loop; the rest stay plain on/off
    generate
        for (g = 0; g < NUM_PID; g++) begin : gPid
            sapc_loop_if lif ();
            assign lif.pidEnable = pidEnable[g];
            assign lif.remote = remoteVec[g];
            assign lif.state = stateVec[g];
            assign lif.manualValue = manualValue[g];
            assign lif.algoValid = pidAlgoValid[g];
            assign lif.algoErr = pidAlgoErr[g*LOOP_W +: LOOP_W];
            assign lif.algoInt = pidAlgoInt[g*LOOP_W +: LOOP_W];
            assign lif.algoOut = pidAlgoOut[g*LOOP_W +: LOOP_W];
            sapc_pid_loop uLoop (
                .sys_clk(sys_clk),
                .rst(rst),
                .clkEn(clkEn),
                .lp(lif.loop)
            );
            assign modeVec[g] = lif.mode;
            assign loopMode[g*MODE_W +: MODE_W] = lif.mode;
            assign loopOutput[g*LOOP_W +: LOOP_W] = lif.outValue;
            assign loopPrevError[g*LOOP_W +: LOOP_W] = lif.prevError;
            assign loopIntegral[g*LOOP_W +: LOOP_W] = lif.integral;
        end
    endgenerate

    assign setpointState = stateVec;
    assign setpointRemote = remoteVec;

    // Readback shows setpoint decisions only; relay timing is elsewhere
    always_comb begin
        next_regRdData = WORD_RST;
        next_regRdData[STATE_LSB +: NUM_SP] = stateVec;
        next_regRdData[REMOTE_LSB +: NUM_SP] = remoteVec;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= WORD_RST;
        end else if (clkEn) begin
            regRdData <= next_regRdData;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence wrStrobe;
        clkEn && regWrEn;
    endsequence

    sequence idleStep;
        clkEn && !regWrEn;
    endsequence

    rd_state_a: assert property (clkEn |=> regRdData[STATE_LSB +: NUM_SP] == $past(stateVec))
        else $error("status field does not follow setpoint state");

    rd_remote_a: assert property (clkEn |=> regRdData[REMOTE_LSB +: NUM_SP] == $past(remoteVec))
        else $error("remote field does not follow remote flags");

    remote_write_a: assert property (wrStrobe |=> remoteVec == $past(regWrData[REMOTE_LSB +: NUM_SP]))
        else $error("remote flags not taken from write");

    state_write_a: assert property (wrStrobe |=> stateVec == (($past(regWrData[REMOTE_LSB +: NUM_SP]) & $past(regWrData[STATE_LSB +: NUM_SP])) | (~$past(regWrData[REMOTE_LSB +: NUM_SP]) & $past(compareResult))))
        else $error("status write handled wrongly");

    remote_hold_a: assert property (idleStep |=> (stateVec & remoteVec) == ($past(stateVec) & $past(remoteVec)))
        else $error("remote setpoint changed without a write");

    normal_compare_a: assert property (idleStep |=> (stateVec & ~remoteVec) == ($past(compareResult) & ~$past(remoteVec)))
        else $error("normal setpoint ignores compare result");

    reset_default_a: assert property (disable iff (1'b0) rst |=> remoteVec == REMOTE_RST && modeVec[0] == SAPC_AUTO)
        else $error("reset defaults wrong");

    generate
        for (g = 0; g < NUM_PID; g++) begin : gChk
            off_clear_a: assert property (modeVec[g] == SAPC_OFF |-> loopOutput[g*LOOP_W +: LOOP_W] == LOOP_RST && loopIntegral[g*LOOP_W +: LOOP_W] == LOOP_RST && loopPrevError[g*LOOP_W +: LOOP_W] == LOOP_RST)
                else $error("off loop registers not cleared");
            manual_out_a: assert property (clkEn && pidEnable[g] && remoteVec[g] && stateVec[g] |=> modeVec[g] == SAPC_MANUAL && loopOutput[g*LOOP_W +: LOOP_W] == $past(manualValue[g]))
                else $error("manual output not applied");
            auto_run_a: assert property (clkEn && pidEnable[g] && !remoteVec[g] && pidAlgoValid[g] |=> modeVec[g] == SAPC_AUTO && loopOutput[g*LOOP_W +: LOOP_W] == $past(pidAlgoOut[g*LOOP_W +: LOOP_W]))
                else $error("auto loop not driven by algorithm");
        end
    endgenerate
endmodule // sapc_top
`default_nettype wire
